// [hw/hia_aggregator.v]
// Hub interrupt aggregator: per-source enables, global enable, pending status.
// Assumes an AHB-Lite master on mclk; event and clear inputs come from logic on mclk.
`timescale 1ns/10ps
`include "hia_consts.vh"

module hia_aggregator (
    input  wire        mclk,         // Clock, 50 MHz
    input  wire        srst,         // Synchronous reset, active high
    input  wire        hsel,         // AHB slave select
    input  wire [31:0] haddr,        // AHB address
    input  wire [1:0]  htrans,       // AHB transfer type
    input  wire        hwrite,       // AHB write
    input  wire [2:0]  hsize,        // AHB size
    input  wire [31:0] hwdata,       // AHB write data
    input  wire        hready,       // AHB ready in
    output reg  [31:0] hrdata,       // AHB read data
    output reg         hreadyout,    // AHB ready out
    output reg         hresp,        // AHB response, always OKAY
    input  wire [5:0]  src_event,    // Source event pulses: tx1,tx0,rx3..rx0
    input  wire [5:0]  src_clear,    // Clearing-read pulses from source units
    output reg         irq_out       // Interrupt to host, level, active high
);

    // Bus phases; a read inserts one wait state so hrdata can leave a flop
    localparam [1:0] BUS_IDLE    = 2'b00;
    localparam [1:0] BUS_WRITE   = 2'b01;
    localparam [1:0] BUS_RD_WAIT = 2'b10;
    localparam [1:0] BUS_RD_DONE = 2'b11;

    reg  [1:0]             bus_q;
    reg  [1:0]             bus_d;
    reg  [`HIA_ADDR_MSB:0] addr_q;
    reg  [`HIA_ADDR_MSB:0] addr_d;
    reg  [7:0]             ctl_q;
    reg  [7:0]             ctl_d;
    reg  [31:0]            rdata_d;
    reg  [31:0]            hrdata_d;
    reg                    hreadyout_d;
    reg                    irq_d;

    wire                   take;
    wire                   take_rd;
    wire                   take_wr;
    wire                   sel_ctl;
    wire                   sel_sts;
    wire                   wr_ctl;

    wire [5:0]             pend;
    wire [5:0]             enables;
    wire [5:0]             active;
    wire                   summary;
    wire                   global_enable;
    wire                   tx1_irq_enable;
    wire                   tx0_irq_enable;
    wire                   receiver3_irq_enable;
    wire                   receiver2_irq_enable;
    wire                   receiver1_irq_enable;
    wire                   receiver0_irq_enable;
    wire                   tx1_irq_pending;
    wire                   tx0_irq_pending;
    wire                   receiver3_irq_pending;
    wire                   receiver2_irq_pending;
    wire                   receiver1_irq_pending;
    wire                   receiver0_irq_pending;
    wire                   tx1_irq_event;
    wire                   tx0_irq_event;
    wire                   receiver3_irq_event;
    wire                   receiver2_irq_event;
    wire                   receiver1_irq_event;
    wire                   receiver0_irq_event;
    wire                   tx1_irq_clear;
    wire                   tx0_irq_clear;
    wire                   receiver3_irq_clear;
    wire                   receiver2_irq_clear;
    wire                   receiver1_irq_clear;
    wire                   receiver0_irq_clear;
    wire [7:0]             ctl_rd;
    wire [7:0]             sts_rd;

    // Address phase is accepted only while the bus is ready
    assign take    = hsel & hready & htrans[1];
    assign take_rd = take & ~hwrite;
    assign take_wr = take & hwrite;
    assign sel_ctl = (addr_q == `HIA_CTL_ADDR);
    assign sel_sts = (addr_q == `HIA_STS_ADDR);
    assign wr_ctl  = (bus_q == BUS_WRITE) & hready & sel_ctl;

    // Enable fields
    assign global_enable        = ctl_q[`HIA_GLOBAL_BIT];
    assign tx1_irq_enable       = ctl_q[`HIA_TX1_BIT];
    assign tx0_irq_enable       = ctl_q[`HIA_TX0_BIT];
    assign receiver3_irq_enable = ctl_q[`HIA_RX3_BIT];
    assign receiver2_irq_enable = ctl_q[`HIA_RX2_BIT];
    assign receiver1_irq_enable = ctl_q[`HIA_RX1_BIT];
    assign receiver0_irq_enable = ctl_q[`HIA_RX0_BIT];

    // Pending fields
    assign tx1_irq_pending       = pend[`HIA_TX1_BIT];
    assign tx0_irq_pending       = pend[`HIA_TX0_BIT];
    assign receiver3_irq_pending = pend[`HIA_RX3_BIT];
    assign receiver2_irq_pending = pend[`HIA_RX2_BIT];
    assign receiver1_irq_pending = pend[`HIA_RX1_BIT];
    assign receiver0_irq_pending = pend[`HIA_RX0_BIT];

    // Event pulses from the source units
    assign tx1_irq_event       = src_event[`HIA_TX1_BIT];
    assign tx0_irq_event       = src_event[`HIA_TX0_BIT];
    assign receiver3_irq_event = src_event[`HIA_RX3_BIT];
    assign receiver2_irq_event = src_event[`HIA_RX2_BIT];
    assign receiver1_irq_event = src_event[`HIA_RX1_BIT];
    assign receiver0_irq_event = src_event[`HIA_RX0_BIT];

    // Clearing-read pulses from the source units
    assign tx1_irq_clear       = src_clear[`HIA_TX1_BIT];
    assign tx0_irq_clear       = src_clear[`HIA_TX0_BIT];
    assign receiver3_irq_clear = src_clear[`HIA_RX3_BIT];
    assign receiver2_irq_clear = src_clear[`HIA_RX2_BIT];
    assign receiver1_irq_clear = src_clear[`HIA_RX1_BIT];
    assign receiver0_irq_clear = src_clear[`HIA_RX0_BIT];

    assign enables = {tx1_irq_enable, tx0_irq_enable, receiver3_irq_enable,
                      receiver2_irq_enable, receiver1_irq_enable, receiver0_irq_enable};
    assign active  = pend & enables;
    assign summary = |active;

    always @* begin
        bus_d  = BUS_IDLE;
        addr_d = addr_q;
        if (take) begin
            addr_d = haddr[`HIA_ADDR_MSB:0];
            if (take_wr) begin
                bus_d = BUS_WRITE;
            end else begin
                bus_d = BUS_RD_WAIT;
            end
        end else begin
            case (bus_q)
                BUS_RD_WAIT: begin
                    bus_d = BUS_RD_DONE;
                end
                default: begin
                    bus_d = BUS_IDLE;
                end
            endcase
        end
    end

    // Control write lands in the data phase; reserved bit 6 stays zero
    always @* begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = hwdata[7:0] & `HIA_CTL_WMASK;
        end
    end

    assign ctl_rd = ctl_q;
    assign sts_rd = {summary, 1'b0, pend};

    // Unmapped offsets read zero; the status register ignores writes
    always @* begin
        case (addr_q)
            `HIA_CTL_ADDR: begin
                rdata_d = {24'h000000, ctl_rd};
            end
            `HIA_STS_ADDR: begin
                rdata_d = {24'h000000, sts_rd};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // Read data loads in the wait state and stands when hreadyout rises
    always @* begin
        hrdata_d = hrdata;
        if (bus_q == BUS_RD_WAIT) begin
            hrdata_d = rdata_d;
        end
        hreadyout_d = (bus_d != BUS_RD_WAIT);
        irq_d       = summary & global_enable;
    end

    always @(posedge mclk) begin
        if (srst) begin
            bus_q     <= BUS_IDLE;
            addr_q    <= 10'h000;
            ctl_q     <= `HIA_CTL_RESET;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            irq_out   <= 1'b0;
        end else begin
            bus_q     <= bus_d;
            addr_q    <= addr_d;
            ctl_q     <= ctl_d;
            hrdata    <= hrdata_d;
            hreadyout <= hreadyout_d;
            hresp     <= 1'b0;
            irq_out   <= irq_d;
        end
    end

    // One sticky cell per source, reset to no pending source
    hia_pend_cell #(
        .RST_VAL (1'b0)
    ) pend_tx1_u (
        .mclk    (mclk),                 // Clock
        .srst    (srst),                 // Reset
        .set_in  (tx1_irq_event),        // Event
        .clr_in  (tx1_irq_clear),
        .flag    (pend[`HIA_TX1_BIT])
    );

    hia_pend_cell #(
        .RST_VAL (1'b0)
    ) pend_tx0_u (
        .mclk    (mclk),                 // Clock
        .srst    (srst),                 // Reset
        .set_in  (tx0_irq_event),        // Event
        .clr_in  (tx0_irq_clear),
        .flag    (pend[`HIA_TX0_BIT])
    );

    hia_pend_cell #(
        .RST_VAL (1'b0)
    ) pend_rx3_u (
        .mclk    (mclk),                 // Clock
        .srst    (srst),                 // Reset
        .set_in  (receiver3_irq_event),  // Event
        .clr_in  (receiver3_irq_clear),
        .flag    (pend[`HIA_RX3_BIT])
    );

    hia_pend_cell #(
        .RST_VAL (1'b0)
    ) pend_rx2_u (
        .mclk    (mclk),                 // Clock
        .srst    (srst),                 // Reset
        .set_in  (receiver2_irq_event),  // Event
        .clr_in  (receiver2_irq_clear),
        .flag    (pend[`HIA_RX2_BIT])
    );

    hia_pend_cell #(
        .RST_VAL (1'b0)
    ) pend_rx1_u (
        .mclk    (mclk),                 // Clock
        .srst    (srst),                 // Reset
        .set_in  (receiver1_irq_event),  // Event
        .clr_in  (receiver1_irq_clear),
        .flag    (pend[`HIA_RX1_BIT])
    );

    hia_pend_cell #(
        .RST_VAL (1'b0)
    ) pend_rx0_u (
        .mclk    (mclk),                 // Clock
        .srst    (srst),                 // Reset
        .set_in  (receiver0_irq_event),  // Event
        .clr_in  (receiver0_irq_clear),
        .flag    (pend[`HIA_RX0_BIT])
    );

endmodule // hia_aggregator

// One sticky pending flag; an event beats a clear in the same cycle
module hia_pend_cell #(
    parameter RST_VAL = 1'b0              // Level after reset
) (
    input  wire mclk,                     // Clock
    input  wire srst,                     // Synchronous reset, active high
    input  wire set_in,                   // Event pulse from the source unit
    input  wire clr_in,                   // Clearing-read pulse from the source unit
    output wire flag                      // Pending flag
);

    reg flag_q;
    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (clr_in) begin
            flag_d = 1'b0;
        end
        if (set_in) begin
            flag_d = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            flag_q <= RST_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

endmodule // hia_pend_cell

// [hw/hia_consts.vh]
// Constants for the hub interrupt aggregator: offsets, field positions, resets.
// Assumes inclusion by bare name from the aggregator design file.
`ifndef HIA_CONSTS_VH
`define HIA_CONSTS_VH
`define HIA_CTL_IDX      8'h23
`define HIA_STS_IDX      8'h24
`define HIA_CTL_ADDR     10'h08c
`define HIA_STS_ADDR     10'h090
`define HIA_CTL_RESET    8'h00
`define HIA_STS_RESET    6'h00
`define HIA_GLOBAL_BIT   7
`define HIA_SUMMARY_BIT  7
`define HIA_SRC_MSB      5
`define HIA_ADDR_MSB     9
`define HIA_CTL_WMASK    8'hbf
`define HIA_TX1_BIT      5
`define HIA_TX0_BIT      4
`define HIA_RX3_BIT      3
`define HIA_RX2_BIT      2
`define HIA_RX1_BIT      1
`define HIA_RX0_BIT      0
`endif

// [sim/hia_asserts.sv]
// Checker on the aggregator top ports; bound to every hia_aggregator.
// Assumes one mclk domain and the synchronous active-high srst.
`timescale 1ns/10ps
`include "hia_consts.vh"
module hia_chk (
    input wire        mclk,       // Clock
    input wire        srst,       // Reset
    input wire        hsel,       // Slave select
    input wire [31:0] haddr,      // Address
    input wire [1:0]  htrans,     // Transfer type
    input wire        hwrite,     // Write
    input wire        hready,     // Ready in
    input wire [31:0] hrdata,     // Read data
    input wire        hreadyout,  // Ready out
    input wire        hresp,      // Response
    input wire [5:0]  src_event,  // Source events
    input wire [5:0]  src_clear,  // Source clears
    input wire        irq_out     // Interrupt
);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
sequence s_take_rd; hsel && hready && htrans[1] && !hwrite; endsequence
sequence s_take_wr; hsel && hready && htrans[1] && hwrite; endsequence
sequence s_reg_rd;
    s_take_rd ##0 ((haddr[9:0] == `HIA_CTL_ADDR) || (haddr[9:0] == `HIA_STS_ADDR));
endsequence
sequence s_rd_data; !hreadyout ##1 hreadyout; endsequence
sequence s_clear_all;
    ((src_clear == 6'h3f) && (src_event == 6'h00)) ##1 (src_event == 6'h00);
endsequence
chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
chk_irq_reset: assert property ($fell(srst) |-> !irq_out) else $error("irq after reset");
chk_read_wait: assert property (s_take_rd |=> s_rd_data) else $error("read wait wrong");
chk_write_nowait: assert property (s_take_wr |=> hreadyout) else $error("write stalled");
chk_rsvd_zero: assert property (s_reg_rd |=> !hreadyout ##1 (hrdata[31:8] == 24'h000000 && !hrdata[6])) else $error("reserved bits set");
chk_irq_clears: assert property (s_clear_all |=> !irq_out) else $error("irq after clear");
endmodule // hia_chk
bind hia_aggregator hia_chk chk_u (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event), .src_clear(src_clear),
    .irq_out(irq_out));

// [sim/hia_host.sv]
// Host side: samples the interrupt level each rising mclk edge.
`timescale 1ns/10ps
module hia_host(input wire mclk, input wire irq_out, output reg irq_seen);
initial irq_seen = 1'b0;
always @(posedge mclk) irq_seen <= irq_out;
endmodule // hia_host

// [sim/tb.sv]
// Bench: AHB-Lite master, source pulses, host model; hready fed from hreadyout.
`timescale 1ns/10ps
`include "hia_consts.vh"
module tb;
reg mclk=0, srst=1, hsel=0, hwrite=0; reg [1:0] htrans=0; reg [31:0] haddr=0, hwdata=0, r;
reg [5:0] src_event=0, src_clear=0; wire [31:0] hrdata; wire hreadyout, hresp, irq_out, irq_seen;
integer err_total=0, total_checks=0;
hia_aggregator dut_u(.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
 .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
 .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event), .src_clear(src_clear),
 .irq_out(irq_out));
hia_host host_u(.mclk(mclk), .irq_out(irq_out), .irq_seen(irq_seen));
initial forever #10 mclk = ~mclk;
task chk(input [31:0] s, input [31:0] e); begin total_checks = total_checks+1;
 if (s !== e) begin err_total = err_total+1; $display("CHECK FAILED %0t %h %h", $time, s, e); end
end endtask
task bus(input w, input [31:0] a, input [31:0] d); begin
 hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
 do @(posedge mclk); while (hreadyout !== 1'b1);
 htrans <= 2'h0; hwdata <= d;
 do @(posedge mclk); while (hreadyout !== 1'b1);
 r = hrdata;
end endtask
task ev(input [5:0] e, input [5:0] c); begin
 src_event <= e; src_clear <= c; @(posedge mclk);
 src_event <= 0; src_clear <= 0; repeat (3) @(posedge mclk);
end endtask
task final_report; begin
 if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
 else $display("CHECKS NOT OK");
 $finish;
end endtask
task t_reset; begin bus(0, `HIA_CTL_ADDR, 0); chk(r, 0);
 bus(0, `HIA_STS_ADDR, 0); chk(r, 0); end endtask
task t_flow; begin
 bus(1, `HIA_CTL_ADDR, 32'hff); bus(0, `HIA_CTL_ADDR, 0); chk(r, 32'hbf);
 ev(6'h01, 0); bus(0, `HIA_STS_ADDR, 0); chk(r, 32'h81);
 chk(irq_seen, 1);
 bus(1, `HIA_CTL_ADDR, 32'h3e); bus(1, `HIA_STS_ADDR, 32'hff);
 bus(0, `HIA_STS_ADDR, 0); chk(r, 32'h01);
 ev(6'h20, 6'h01); bus(0, `HIA_STS_ADDR, 0); chk(r, 32'ha0);
 chk(irq_out, 0);
 ev(0, 6'h20); bus(0, `HIA_STS_ADDR, 0); chk(r, 0);
 ev(6'h10, 6'h10); bus(0, `HIA_STS_ADDR, 0); chk(r, 32'h90);
 ev(0, 6'h3f); bus(0, `HIA_STS_ADDR, 0); chk(r, 0);
end endtask
initial begin #100000; err_total = err_total+1; final_report; end
initial begin repeat (12) @(posedge mclk); srst <= 0; @(posedge mclk);
 t_reset; t_flow; final_report; end
endmodule // tb
